//--- logic/iop_pin.sv
`timescale 1ns/10ps
module iop_pin
	import iop_pkg::*;
(
	// Clock and control
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       run_i,
	input  wire logic       hold_i,
	// Configuration
	input  wire logic [2:0] mode_i,
	input  wire logic       dout_i,
	input  wire logic       regulated_i,
	input  wire logic [1:0] irq_mode_i,
	input  wire logic       irq_clr_i,
	// Boundary scan
	input  wire logic       bs_mode_i,
	input  wire logic       bs_capture_i,
	input  wire logic       bs_shift_i,
	input  wire logic       bs_update_i,
	input  wire logic       bs_si_i,
	output logic            bs_so_o,
	// Pad
	input  wire logic       pad_i,
	output logic            pad_o,
	output logic            pad_oe_n_o,
	output logic            pad_pu_o,
	output logic            pad_pd_o,
	output logic            pad_ibuf_en_o,
	// Status
	output logic            din_o,
	output logic            irq_evt_o,
	output logic            irq_sts_o
);

	logic       sync1_r, sync2_r, prev_r, out_r, oe_n_r, pu_r, pd_r, ibuf_r, sts_r;
	logic       sync1_nxt, sync2_nxt, prev_nxt, out_nxt, oe_n_nxt, pu_nxt, pd_nxt;
	logic       ibuf_nxt, sts_nxt;
	logic [1:0] bscap_r, bscap_nxt, bsupd_r, bsupd_nxt;
	logic [2:0] mode_eff;
	logic       drv_hi, drv_lo, res_hi, res_lo, rise, fall, evt, din;

	// Input path, edge events, drive decode and scan cell
	always_comb begin
		mode_eff = mode_i;
		if (regulated_i && (mode_i == DM_RES_PULL_UP || mode_i == DM_RES_PULL_DN ||
			mode_i == DM_RES_BOTH)) begin
			mode_eff = DM_HIZ_DIGITAL;
		end
		drv_hi = 1'b0;
		drv_lo = 1'b0;
		res_hi = 1'b0;
		res_lo = 1'b0;
		unique case (mode_eff)
			DM_HIZ_ANALOG, DM_HIZ_DIGITAL: begin
			end
			DM_RES_PULL_UP: begin
				res_hi = dout_i;
				drv_lo = !dout_i;
			end
			DM_RES_PULL_DN: begin
				drv_hi = dout_i;
				res_lo = !dout_i;
			end
			DM_OD_LOW:  drv_lo = !dout_i;
			DM_OD_HIGH: drv_hi = dout_i;
			DM_STRONG: begin
				drv_hi = dout_i;
				drv_lo = !dout_i;
			end
			DM_RES_BOTH: begin
				res_hi = dout_i;
				res_lo = !dout_i;
			end
		endcase
		// Pad drive: analog until loaded, scan override, retention, normal
		out_nxt  = out_r;
		oe_n_nxt = oe_n_r;
		pu_nxt   = pu_r;
		pd_nxt   = pd_r;
		ibuf_nxt = ibuf_r;
		if (!run_i) begin
			out_nxt  = 1'b0;
			oe_n_nxt = 1'b1;
			pu_nxt   = 1'b0;
			pd_nxt   = 1'b0;
			ibuf_nxt = 1'b0;
		end else if (bs_mode_i) begin
			out_nxt  = bsupd_r[0];
			oe_n_nxt = !bsupd_r[1];
			pu_nxt   = 1'b0;
			pd_nxt   = 1'b0;
			ibuf_nxt = 1'b1;
		end else if (!hold_i) begin
			out_nxt  = dout_i;
			oe_n_nxt = !(drv_hi || drv_lo);
			pu_nxt   = res_hi;
			pd_nxt   = res_lo;
			ibuf_nxt = (mode_eff != DM_HIZ_ANALOG);
		end
		// Input synchroniser and edge detect
		sync1_nxt = pad_i;
		sync2_nxt = sync1_r;
		din       = sync2_r && ibuf_r;
		prev_nxt  = din;
		rise      = din && !prev_r;
		fall      = !din && prev_r;
		unique case (irq_mode_i)
			IRQ_NONE: evt = 1'b0;
			IRQ_RISE: evt = rise;
			IRQ_FALL: evt = fall;
			IRQ_BOTH: evt = rise || fall;
		endcase
		sts_nxt = evt || (sts_r && !irq_clr_i);
		// Scan cell: capture {driving, pin}, shift toward so, update
		bscap_nxt = bscap_r;
		bsupd_nxt = bsupd_r;
		if (bs_capture_i) begin
			bscap_nxt = {!oe_n_r, sync2_r};
		end else if (bs_shift_i) begin
			bscap_nxt = {bs_si_i, bscap_r[1]};
		end
		if (bs_update_i) begin
			bsupd_nxt = bscap_r;
		end
	end

	// State registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
			out_r   <= 1'b0;
			oe_n_r  <= 1'b1;
			pu_r    <= 1'b0;
			pd_r    <= 1'b0;
			ibuf_r  <= 1'b0;
			sts_r   <= 1'b0;
			bscap_r <= 2'h0;
			bsupd_r <= 2'h0;
		end else if (ce_i) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r  <= prev_nxt;
			out_r   <= out_nxt;
			oe_n_r  <= oe_n_nxt;
			pu_r    <= pu_nxt;
			pd_r    <= pd_nxt;
			ibuf_r  <= ibuf_nxt;
			sts_r   <= sts_nxt;
			bscap_r <= bscap_nxt;
			bsupd_r <= bsupd_nxt;
		end
	end

	assign pad_o         = out_r;
	assign pad_oe_n_o    = oe_n_r;
	assign pad_pu_o      = pu_r;
	assign pad_pd_o      = pd_r;
	assign pad_ibuf_en_o = ibuf_r;
	assign din_o         = din;
	assign irq_evt_o     = evt;
	assign irq_sts_o     = sts_r;
	assign bs_so_o       = bscap_r[0];

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	AST_REG_NO_RES: assert property (ce_i && run_i && !bs_mode_i && !hold_i && regulated_i
		|=> !pad_pu_o && !pad_pd_o) else $error("resistive drive on regulated pin");
	AST_RETAIN: assert property (ce_i && run_i && !bs_mode_i && hold_i
		|=> $stable(pad_oe_n_o) && $stable(pad_pu_o) && $stable(pad_pd_o) && $stable(pad_o))
		else $error("pin drive changed in low-power mode");
	AST_NO_EDGE_NONE: assert property (ce_i && irq_mode_i == IRQ_NONE && !irq_sts_o
		|=> !irq_sts_o) else $error("event flagged with edge detect off");
	AST_SET_WINS: assert property (ce_i && irq_evt_o && irq_clr_i |=> irq_sts_o)
		else $error("event lost against clear");
	AST_BS_DRIVE: assert property (ce_i && run_i && bs_mode_i |=> pad_o == $past(bsupd_r[0]))
		else $error("scan cell not driving pin");

endmodule : iop_pin

//--- logic/iop_pkg.sv
package iop_pkg;

	// Drive modes of one pin
	localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
	localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] DM_RES_PULL_UP = 3'h2;
	localparam logic [2:0] DM_RES_PULL_DN = 3'h3;
	localparam logic [2:0] DM_OD_LOW      = 3'h4;
	localparam logic [2:0] DM_OD_HIGH     = 3'h5;
	localparam logic [2:0] DM_STRONG      = 3'h6;
	localparam logic [2:0] DM_RES_BOTH    = 3'h7;

	// Edge selection for pin events
	localparam logic [1:0] IRQ_NONE = 2'h0;
	localparam logic [1:0] IRQ_RISE = 2'h1;
	localparam logic [1:0] IRQ_FALL = 2'h2;
	localparam logic [1:0] IRQ_BOTH = 2'h3;

	// Port reset state codes
	localparam logic [1:0] RCFG_HIZ     = 2'h0;
	localparam logic [1:0] RCFG_PULL_DN = 2'h1;
	localparam logic [1:0] RCFG_PULL_UP = 2'h2;

	// Pair input threshold codes
	localparam logic [1:0] VTH_HALF_VDDIO = 2'h0;
	localparam logic [1:0] VTH_04_VDDIO   = 2'h1;
	localparam logic [1:0] VTH_HALF_VREF  = 2'h2;
	localparam logic [1:0] VTH_VREF       = 2'h3;

	// Special pin input buffer modes
	localparam logic [1:0] INM_CMOS  = 2'h0;
	localparam logic [1:0] INM_LVTTL = 2'h1;
	localparam logic [1:0] INM_DIFF  = 2'h2;

	// Reset values
	localparam logic [1:0] RCFG_RST = RCFG_HIZ;
	localparam logic [1:0] VTH_RST  = VTH_HALF_VDDIO;
	localparam logic [1:0] INM_RST  = INM_CMOS;
	localparam logic [2:0] DM_RST   = DM_HIZ_ANALOG;
	localparam logic [1:0] IRQ_RST  = IRQ_NONE;

	// Sequence after reset release
	typedef enum logic [1:0] {ST_LOAD, ST_APPLY, ST_RUN} iop_state_t;

endpackage : iop_pkg

//--- logic/iop_port.sv
`timescale 1ns/10ps
module iop_port
	import iop_pkg::*;
#(
	parameter int                NPIN          = 8,
	parameter int                NSIO          = 2,
	parameter logic [NPIN-1:0]   I2C_WAKE_MASK = {{(NPIN-1){1'b0}}, 1'b1}
) (
	// Clock, reset, enable
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 ce_i,
	// Reset configuration
	input  wire logic [1:0]           nv_rst_cfg_i,
	input  wire logic                 rst_cfg_wr_i,
	input  wire logic [1:0]           rst_cfg_wdata_i,
	output logic [1:0]                rst_cfg_o,
	output logic                      cfg_ready_o,
	// Pin configuration
	input  wire logic                 pin_cfg_wr_i,
	input  wire logic [3*NPIN-1:0]    drv_mode_i,
	input  wire logic [NPIN-1:0]      dout_i,
	input  wire logic [2*NPIN-1:0]    irq_mode_i,
	input  wire logic [NPIN-1:0]      irq_clr_i,
	output logic [3*NPIN-1:0]         drv_mode_o,
	output logic [NPIN-1:0]           din_o,
	output logic [NPIN-1:0]           irq_sts_o,
	output logic                      irq_o,
	// Special pin configuration
	input  wire logic                 sio_cfg_wr_i,
	input  wire logic [NSIO-1:0]      sio_reg_sel_i,
	input  wire logic [NSIO-1:0]      sio_vth_sel_i,
	input  wire logic [1:0]           sio_in_mode_i,
	input  wire logic [NSIO/2-1:0]    sio_cmp_ag_i,
	input  wire logic [NSIO-1:0]      sio_hyst_en_i,
	output logic [NSIO-1:0]           sio_vout_reg_o,
	output logic [NSIO-1:0]           sio_vth_sel_o,
	output logic [1:0]                sio_in_mode_o,
	output logic [NSIO/2-1:0]         sio_cmp_ag_o,
	output logic [NSIO/2-1:0]         sio_ref_en_o,
	output logic [NSIO-1:0]           sio_hyst_en_o,
	// Low power and wake
	input  wire logic                 lp_mode_i,
	input  wire logic                 i2c_match_i,
	input  wire logic [NPIN-1:0]      i2c_wake_en_i,
	output logic                      wake_o,
	// Boundary scan
	input  wire logic                 bs_mode_i,
	input  wire logic                 bs_capture_i,
	input  wire logic                 bs_shift_i,
	input  wire logic                 bs_update_i,
	input  wire logic                 bs_tdi_i,
	output logic                      bs_tdo_o,
	// Pads
	input  wire logic [NPIN-1:0]      pad_i,
	output logic [NPIN-1:0]           pad_o,
	output logic [NPIN-1:0]           pad_oe_n_o,
	output logic [NPIN-1:0]           pad_pu_o,
	output logic [NPIN-1:0]           pad_pd_o,
	output logic [NPIN-1:0]           pad_ibuf_en_o
);

	localparam int NPAIR = NSIO / 2;

	iop_state_t          state_r, state_nxt;
	logic [1:0]          rst_cfg_r, rst_cfg_nxt;
	logic [3*NPIN-1:0]   drv_r, drv_nxt;
	logic [NPIN-1:0]     dout_r, dout_nxt;
	logic [2*NPIN-1:0]   irqm_r, irqm_nxt;
	logic [NSIO-1:0]     sreg_r, sreg_nxt, svth_r, svth_nxt, shyst_r, shyst_nxt;
	logic [1:0]          sinm_r, sinm_nxt;
	logic [NPAIR-1:0]    sag_r, sag_nxt;
	logic                wake_r, wake_nxt;
	logic [NPIN-1:0]     evt;
	logic [NPIN-1:0]     regulated;
	logic [NPIN:0]       chain;
	logic                run;
	logic                cfg_open;

	// Drive mode that a port reset state stands for
	function automatic logic [2:0] rcfg_mode(input logic [1:0] cfg);
		logic [2:0] m;
		unique case (cfg)
			RCFG_PULL_UP: m = DM_RES_PULL_UP;
			RCFG_PULL_DN: m = DM_RES_PULL_DN;
			default:      m = DM_HIZ_ANALOG;
		endcase
		return m;
	endfunction : rcfg_mode

	assign run      = (state_r == ST_RUN);
	assign cfg_open = run && !lp_mode_i;

	// Reset sequence and pin configuration
	always_comb begin
		state_nxt   = state_r;
		rst_cfg_nxt = rst_cfg_r;
		drv_nxt     = drv_r;
		dout_nxt    = dout_r;
		irqm_nxt    = irqm_r;
		unique case (state_r)
			ST_LOAD: begin
				rst_cfg_nxt = nv_rst_cfg_i;
				state_nxt   = ST_APPLY;
			end
			ST_APPLY: begin
				drv_nxt   = {NPIN{rcfg_mode(rst_cfg_r)}};
				dout_nxt  = {NPIN{rst_cfg_r == RCFG_PULL_UP}};
				state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (cfg_open && rst_cfg_wr_i) begin
					rst_cfg_nxt = rst_cfg_wdata_i;
					drv_nxt     = {NPIN{rcfg_mode(rst_cfg_wdata_i)}};
					dout_nxt    = {NPIN{rst_cfg_wdata_i == RCFG_PULL_UP}};
				end else if (cfg_open && pin_cfg_wr_i) begin
					drv_nxt  = drv_mode_i;
					dout_nxt = dout_i;
					irqm_nxt = irq_mode_i;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_r   <= ST_LOAD;
			rst_cfg_r <= RCFG_RST;
			drv_r     <= {NPIN{DM_RST}};
			dout_r    <= '0;
			irqm_r    <= {NPIN{IRQ_RST}};
		end else if (ce_i) begin
			state_r   <= state_nxt;
			rst_cfg_r <= rst_cfg_nxt;
			drv_r     <= drv_nxt;
			dout_r    <= dout_nxt;
			irqm_r    <= irqm_nxt;
		end
	end

	// Special pin output level, threshold and input mode settings
	always_comb begin
		sreg_nxt  = sreg_r;
		svth_nxt  = svth_r;
		sinm_nxt  = sinm_r;
		sag_nxt   = sag_r;
		shyst_nxt = shyst_r;
		if (cfg_open && sio_cfg_wr_i) begin
			sreg_nxt  = sio_reg_sel_i;
			svth_nxt  = sio_vth_sel_i;
			sinm_nxt  = sio_in_mode_i;
			sag_nxt   = sio_cmp_ag_i;
			shyst_nxt = sio_hyst_en_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sreg_r  <= '0;
			svth_r  <= {NPAIR{VTH_RST}};
			sinm_r  <= INM_RST;
			sag_r   <= '0;
			shyst_r <= '0;
		end else if (ce_i) begin
			sreg_r  <= sreg_nxt;
			svth_r  <= svth_nxt;
			sinm_r  <= sinm_nxt;
			sag_r   <= sag_nxt;
			shyst_r <= shyst_nxt;
		end
	end

	// Wake request from pin edges or an I2C match on a designated pin
	always_comb begin
		wake_nxt = lp_mode_i && ((|evt) ||
			(i2c_match_i && |(i2c_wake_en_i & I2C_WAKE_MASK)));
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wake_r <= 1'b0;
		end else if (ce_i) begin
			wake_r <= wake_nxt;
		end
	end

	// Special pins are the low pins of the port
	assign regulated = {{(NPIN-NSIO){1'b0}}, sreg_r};
	assign chain[0]  = bs_tdi_i;

	// One cell per pin, scan chain from pin 0 upward
	for (genvar g = 0; g < NPIN; g++) begin : g_pin
		iop_pin u_pin (
			.mclk_i        (mclk_i),
			.rst_n_i       (rst_n_i),
			.ce_i          (ce_i),
			.run_i         (run),
			.hold_i        (lp_mode_i),
			.mode_i        (drv_r[3*g +: 3]),
			.dout_i        (dout_r[g]),
			.regulated_i   (regulated[g]),
			.irq_mode_i    (irqm_r[2*g +: 2]),
			.irq_clr_i     (irq_clr_i[g]),
			.bs_mode_i     (bs_mode_i),
			.bs_capture_i  (bs_capture_i),
			.bs_shift_i    (bs_shift_i),
			.bs_update_i   (bs_update_i),
			.bs_si_i       (chain[g]),
			.bs_so_o       (chain[g+1]),
			.pad_i         (pad_i[g]),
			.pad_o         (pad_o[g]),
			.pad_oe_n_o    (pad_oe_n_o[g]),
			.pad_pu_o      (pad_pu_o[g]),
			.pad_pd_o      (pad_pd_o[g]),
			.pad_ibuf_en_o (pad_ibuf_en_o[g]),
			.din_o         (din_o[g]),
			.irq_evt_o     (evt[g]),
			.irq_sts_o     (irq_sts_o[g])
		);
	end

	// Register views
	assign bs_tdo_o       = chain[NPIN];
	assign rst_cfg_o      = rst_cfg_r;
	assign cfg_ready_o    = run;
	assign drv_mode_o     = drv_r;
	assign irq_o          = |irq_sts_o;
	assign wake_o         = wake_r;
	assign sio_vout_reg_o = sreg_r;
	assign sio_vth_sel_o  = svth_r;
	assign sio_in_mode_o  = sinm_r;
	assign sio_cmp_ag_o   = sag_r;
	assign sio_hyst_en_o  = shyst_r;
	assign sio_ref_en_o   = {NPAIR{sinm_r == INM_DIFF}} | sag_r;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_load;
		state_r == ST_LOAD && ce_i;
	endsequence

	sequence s_apply;
		state_r == ST_APPLY && ce_i;
	endsequence

	property p_reset_hiz;
		@(posedge mclk_i) disable iff (1'b0)
		!rst_n_i |=> (&pad_oe_n_o) && !(|pad_pu_o) && !(|pad_pd_o) && !(|pad_ibuf_en_o);
	endproperty

	AST_RESET_HIZ: assert property (p_reset_hiz)
		else $error("pin left analog state during reset");
	AST_NV_COPY: assert property (s_load |=> rst_cfg_o == $past(nv_rst_cfg_i))
		else $error("nonvolatile reset state not copied");
	AST_LOAD_ORDER: assert property (s_load ##1 s_apply |=> cfg_ready_o)
		else $error("reset sequence did not reach run");
	AST_HIZ_BEFORE_RUN: assert property (!cfg_ready_o
		|-> (&pad_oe_n_o) && !(|pad_pu_o) && !(|pad_pd_o)) else $error("pin driven before load");
	AST_RCFG_WRITE: assert property (ce_i && run && !lp_mode_i && rst_cfg_wr_i
		|=> rst_cfg_o == $past(rst_cfg_wdata_i) && drv_mode_o[2:0] == rcfg_mode(rst_cfg_o))
		else $error("port reset state not reprogrammed");
	AST_WAKE_EDGE: assert property (ce_i && lp_mode_i && (|evt) |=> wake_o)
		else $error("pin event did not wake");
	AST_I2C_MASK: assert property (ce_i && !(|evt) && !(|(i2c_wake_en_i & I2C_WAKE_MASK))
		|=> !wake_o) else $error("wake from non-designated pin");
	AST_SIO_CFG: assert property (ce_i && cfg_open && sio_cfg_wr_i
		|=> sio_vth_sel_o == $past(sio_vth_sel_i) && sio_vout_reg_o == $past(sio_reg_sel_i))
		else $error("special pin settings not taken");

	sequence s_closed;
		ce_i && run && lp_mode_i;
	endsequence

	// Low power closes every configuration write
	AST_LP_FROZEN: assert property (s_closed
		|=> $stable(drv_mode_o) && $stable(rst_cfg_o) && $stable(sio_vth_sel_o))
		else $error("configuration changed in low-power mode");

	// A plain pin write loads drive modes and edge selections together
	AST_PIN_CFG: assert property (ce_i && cfg_open && pin_cfg_wr_i && !rst_cfg_wr_i
		|=> drv_mode_o == $past(drv_mode_i) && irqm_r == $past(irq_mode_i))
		else $error("pin settings not taken");

	// Wake is only ever requested while in low power
	AST_WAKE_LP_ONLY: assert property (ce_i && !lp_mode_i
		|=> !wake_o)
		else $error("wake raised outside low-power mode");

	// The loaded reset state becomes the drive mode of every pin
	AST_APPLY_MODE: assert property (s_apply
		|=> drv_mode_o[2:0] == rcfg_mode(rst_cfg_o))
		else $error("reset state not applied to pins");

	// Input mode and comparator source follow the write
	AST_SIO_MODE: assert property (ce_i && cfg_open && sio_cfg_wr_i
		|=> sio_in_mode_o == $past(sio_in_mode_i) && sio_cmp_ag_o == $past(sio_cmp_ag_i))
		else $error("special pin input settings not taken");

	// An address match on a designated pin wakes the part
	AST_I2C_WAKE: assert property (ce_i && lp_mode_i && i2c_match_i
		&& (|(i2c_wake_en_i & I2C_WAKE_MASK)) |=> wake_o)
		else $error("address match did not wake");

endmodule : iop_port

//--- testbench/iop_ext_model.sv
`timescale 1ns/10ps
module iop_ext_model #(
	parameter int              NPIN        = 8,
	parameter logic [NPIN-1:0] PULLUP_MASK = '0
) (
	// Clock
	input  wire logic            mclk_i,
	// Device pad side
	input  wire logic [NPIN-1:0] drv_i,
	input  wire logic [NPIN-1:0] drv_oe_n_i,
	input  wire logic [NPIN-1:0] pu_i,
	input  wire logic [NPIN-1:0] pd_i,
	// Board side
	input  wire logic [NPIN-1:0] ext_en_i,
	input  wire logic [NPIN-1:0] ext_val_i,
	output logic [NPIN-1:0]      level_o
);
	logic toggle_r = 1'b0;

	// Floating lines wander so a stale level never passes for a driven one
	always @(posedge mclk_i) begin
		toggle_r <= ~toggle_r;
	end

	// Resolve each line from device, board driver and pulls
	always_comb begin
		for (int g = 0; g < NPIN; g++) begin
			if (!drv_oe_n_i[g])
				level_o[g] = drv_i[g];
			else if (ext_en_i[g])
				level_o[g] = ext_val_i[g];
			else if (pu_i[g])
				level_o[g] = 1'b1;
			else if (pd_i[g])
				level_o[g] = 1'b0;
			else if (PULLUP_MASK[g])
				level_o[g] = 1'b1;
			else
				level_o[g] = toggle_r;
		end
	end
endmodule : iop_ext_model

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
	import iop_pkg::*;
	// Stimulus
	logic        mclk_i  = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        rcfg_wr = 1'b0, pin_wr = 1'b0, sio_wr = 1'b0, lp = 1'b0;
	logic        i2c_m   = 1'b0, bs_cap = 1'b0, bs_sh = 1'b0, tdi = 1'b0, ag = 1'b0;
	logic        ce      = 1'b1, bs_md = 1'b0, bs_upd = 1'b0;
	logic [1:0]  rcfg_d  = 2'h0, in_mode = 2'h0, vth = 2'h0, hyst = 2'h0;
	logic [23:0] drv     = 24'h0;
	logic [15:0] irqm    = 16'h0;
	logic [7:0]  dout    = 8'h0, clr = 8'h0, wken = 8'h0, ext_en = 8'hFF, ext_val = 8'h0;
	logic [15:0] pat     = 16'hA5C3;
	// Observed
	logic [1:0]  rcfg_o, vth_o, reg_o, hyst_o, inm_o;
	logic        rdy_o, irq_o, wake_o, tdo_o, ag_o, ref_o;
	logic [23:0] drv_o;
	logic [7:0]  din_o, sts_o, pad_o, oe_n, pu, pd, ibuf, lvl;
	int          errors = 0, checks = 0, cyc = 0;

	always #20 mclk_i = ~mclk_i;

	iop_port u_dut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.nv_rst_cfg_i(RCFG_PULL_UP), .rst_cfg_wr_i(rcfg_wr), .rst_cfg_wdata_i(rcfg_d),
		.rst_cfg_o(rcfg_o), .cfg_ready_o(rdy_o),
		.pin_cfg_wr_i(pin_wr), .drv_mode_i(drv), .dout_i(dout), .irq_mode_i(irqm),
		.irq_clr_i(clr), .drv_mode_o(drv_o), .din_o(din_o), .irq_sts_o(sts_o), .irq_o(irq_o),
		.sio_cfg_wr_i(sio_wr), .sio_reg_sel_i(2'h1), .sio_vth_sel_i(vth),
		.sio_in_mode_i(in_mode), .sio_cmp_ag_i(ag), .sio_hyst_en_i(hyst),
		.sio_vout_reg_o(reg_o), .sio_vth_sel_o(vth_o), .sio_in_mode_o(inm_o),
		.sio_cmp_ag_o(ag_o), .sio_ref_en_o(ref_o), .sio_hyst_en_o(hyst_o),
		.lp_mode_i(lp), .i2c_match_i(i2c_m), .i2c_wake_en_i(wken), .wake_o(wake_o),
		.bs_mode_i(bs_md), .bs_capture_i(bs_cap), .bs_shift_i(bs_sh), .bs_update_i(bs_upd),
		.bs_tdi_i(tdi), .bs_tdo_o(tdo_o),
		.pad_i(lvl), .pad_o(pad_o), .pad_oe_n_o(oe_n), .pad_pu_o(pu), .pad_pd_o(pd),
		.pad_ibuf_en_o(ibuf)
	);

	iop_ext_model #(.NPIN(8), .PULLUP_MASK(8'h80)) u_ext (
		.mclk_i(mclk_i), .drv_i(pad_o), .drv_oe_n_i(oe_n), .pu_i(pu), .pd_i(pd),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl)
	);

	// Cut a hang short
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc > 3000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : step

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// Pin write, returns once the pads reflect it
	task automatic wr_pin(input logic [23:0] m, input logic [7:0] d, input logic [15:0] q);
		drv = m;
		dout = d;
		irqm = q;
		pin_wr = 1'b1;
		step(1);
		pin_wr = 1'b0;
		step(2);
	endtask : wr_pin

	// Expected {oe_n, pu, pd, ibuf} of one pin
	function automatic logic [3:0] exp_pad(input logic [2:0] m, input logic d, input logic rg);
		logic [2:0] e;
		logic       on;
		e = (rg && (m == DM_RES_PULL_UP || m == DM_RES_PULL_DN || m == DM_RES_BOTH))
			? DM_HIZ_DIGITAL : m;
		on = (e == DM_STRONG) || (e == DM_RES_PULL_UP && !d) || (e == DM_RES_PULL_DN && d)
			|| (e == DM_OD_LOW && !d) || (e == DM_OD_HIGH && d);
		return {!on, (e == DM_RES_PULL_UP || e == DM_RES_BOTH) && d,
			(e == DM_RES_PULL_DN || e == DM_RES_BOTH) && !d, e != DM_HIZ_ANALOG};
	endfunction : exp_pad

	// Main sequence
	initial begin
		step(10);
		chk({oe_n, pu, pd, ibuf}, 32'hFF000000);
		rst_n_i = 1'b1;
		step(1);
		chk({rdy_o, oe_n, pu}, {1'b0, 8'hFF, 8'h00});
		step(1);
		chk({rdy_o, rcfg_o, drv_o}, {1'b1, RCFG_PULL_UP, {8{DM_RES_PULL_UP}}});
		step(1);
		chk(pu, 8'hFF);
		// Port reset state rewritten by software, first refused with the clock enable low
		ce = 1'b0;
		rcfg_d = RCFG_PULL_DN;
		rcfg_wr = 1'b1;
		step(2);
		chk({rcfg_o, pu}, {RCFG_PULL_UP, 8'hFF});
		ce = 1'b1;
		step(1);
		rcfg_wr = 1'b0;
		step(3);
		chk({rcfg_o, drv_o, pd}, {RCFG_PULL_DN, {8{DM_RES_PULL_DN}}, 8'hFF});
		// Pair threshold, input mode, comparator and hysteresis
		for (int i = 0; i < 4; i++) begin
			vth = i[1:0];
			in_mode = (i == 3) ? INM_CMOS : i[1:0];
			ag = i[0];
			hyst = i[1:0];
			sio_wr = 1'b1;
			step(1);
			sio_wr = 1'b0;
			step(1);
			chk({vth_o, inm_o, ag_o, hyst_o, reg_o}, {vth, in_mode, ag, hyst, 2'h1});
			chk(ref_o, (in_mode == INM_DIFF) || ag);
		end
		// Every drive mode on a regulated special pin and a plain pin
		for (int m = 0; m < 8; m++) begin
			for (int d = 0; d < 2; d++) begin
				wr_pin({8{m[2:0]}}, {8{d[0]}}, 16'h0);
				chk({oe_n[0], pu[0], pd[0], ibuf[0]}, exp_pad(m[2:0], d[0], 1'b1));
				chk({oe_n[6], pu[6], pd[6], ibuf[6]}, exp_pad(m[2:0], d[0], 1'b0));
			end
		end
		// Open-drain low line with a board pull-up
		ext_en = 8'h7F;
		wr_pin({8{DM_OD_LOW}}, 8'hFF, 16'h0);
		step(3);
		chk(din_o[7], 1'b1);
		wr_pin({8{DM_OD_LOW}}, 8'h00, 16'h0);
		step(3);
		chk(din_o[7], 1'b0);
		ext_en = 8'hFF;
		// Pin 1 rise, pin 2 fall, pin 3 both, others none
		wr_pin({8{DM_HIZ_DIGITAL}}, 8'h00, 16'h00E4);
		step(4);
		clr = 8'hFF;
		step(1);
		clr = 8'h00;
		for (int p = 0; p < 2; p++) begin
			ext_val = p ? 8'h00 : 8'hFF;
			step(5);
			chk({sts_o, irq_o}, {(p ? 8'h0C : 8'h0A), 1'b1});
			clr = 8'hFF;
			step(1);
			clr = 8'h00;
			chk(sts_o, 8'h00);
		end
		// Low power: state held, writes refused, wake sources
		wr_pin({{4{DM_STRONG}}, {4{DM_HIZ_DIGITAL}}}, 8'hF0, 16'h0004);
		lp = 1'b1;
		step(1);
		wr_pin(24'h0, 8'h00, 16'h0);
		chk(drv_o, {{4{DM_STRONG}}, {4{DM_HIZ_DIGITAL}}});
		chk({oe_n, pad_o}, 16'h0FF0);
		wken = 8'h02;
		i2c_m = 1'b1;
		step(3);
		chk(wake_o, 1'b0);
		wken = 8'h01;
		step(2);
		chk(wake_o, 1'b1);
		i2c_m = 1'b0;
		step(2);
		chk(wake_o, 1'b0);
		ext_val[1] = 1'b1;
		for (int k = 0; k < 6 && wake_o !== 1'b1; k++)
			step(1);
		chk(wake_o, 1'b1);
		lp = 1'b0;
		step(1);
		wr_pin(24'h0, 8'h00, 16'h0);
		chk({oe_n, ibuf}, 16'hFF00);
		// Scan chain passes a pattern through every cell
		bs_cap = 1'b1;
		step(1);
		bs_cap = 1'b0;
		bs_sh = 1'b1;
		for (int k = 0; k < 16; k++) begin
			tdi = pat[k];
			step(1);
		end
		for (int k = 0; k < 16; k++) begin
			chk(tdo_o, pat[k]);
			tdi = pat[k];
			step(1);
		end
		bs_sh = 1'b0;
		// Update the reloaded cells and let them drive the pads
		bs_upd = 1'b1;
		step(1);
		bs_upd = 1'b0;
		bs_md = 1'b1;
		step(1);
		chk({oe_n, pad_o}, 16'h6C9C);
		bs_md = 1'b0;
		report_and_stop();
	end
endmodule : tb
